// ### rtl/pfs_params.svh
// Constants for the fail-safe and delayed read supervision block.
// Assumes a 12-bit register offset within the second base address region.
`ifndef PFS_PARAMS_SVH
`define PFS_PARAMS_SVH

// Register offsets
`define PFS_OFS_GLOBAL 12'h800
`define PFS_OFS_CTRL 12'h804
`define PFS_OFS_TMR 12'h808
`define PFS_OFS_PRELOAD 12'h80c
`define PFS_OFS_DTMR 12'h810
`define PFS_OFS_CMD 12'h81c

// Control register fields
`define PFS_B_HOLD 31
`define PFS_B_EN_CORE 21
`define PFS_B_EN_DISC 20
`define PFS_B_EN_FS 19
`define PFS_B_AUTOCLR 18
`define PFS_B_MODE_HI 17
`define PFS_B_MODE_LO 16
`define PFS_CTRL_RST 32'h0002_0000
`define PFS_CTRL_WMASK 32'h803f_0000

// Global activity register fields
`define PFS_G_IRQ 31
`define PFS_G_FIFO 30
`define PFS_G_ONE 24
`define PFS_G_DISC 23
`define PFS_G_FSERR 22
`define PFS_G_CORE 16

// Command register fields
`define PFS_C_CLRFS 1
`define PFS_C_CORERST 0

// Timer values
`define PFS_PRELOAD_RST 16'h8400
`define PFS_DTMR_RST 16'h0000
`define PFS_DTMR_TERM 15

`endif

// ### rtl/pfs_pkg.sv
// Types used by the fail-safe supervision block; its timer defines its own.
// Assumes pfs_params.svh is compiled alongside.
`default_nettype none
package pfs_pkg;

    // Recovery mode field encoding
    typedef enum logic [1:0] {
        PFS_OFF = 2'b00,
        PFS_RETRY = 2'b01,
        PFS_HALT = 2'b10,
        PFS_SKIP = 2'b11
    } pfs_mode_e;

    // State of the supervision block outside its fail-safe timer
    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] preload;
        logic fs_err;
        logic fs_irq;
        logic abort;
        logic disc_flag;
        logic dr_valid;
        logic dr_run;
        logic dr_bar1;
        logic [15:0] dr_cnt;
        logic dr_discard;
        logic reissue;
        logic skip;
        logic core_rst;
        logic irq;
        logic [31:0] rdata;
    } pfs_state_s;

endpackage
`default_nettype wire

// ### rtl/pfs_fs_timer.sv
// Fail-safe down counter for one local bus access.
// Assumes load and done are single-cycle pulses in the clk domain.
`default_nettype none
module pfs_fs_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Control
    input wire logic load,
    input wire logic done,
    input wire logic [W-1:0] preload,
    // Status
    output logic [W-1:0] count,
    output logic busy,
    output logic expire
);

    typedef struct packed {
        logic busy;
        logic [W-1:0] cnt;
    } pfs_tmr_s;

    pfs_tmr_s s_q;
    pfs_tmr_s s_d;

    // Expiry seen the cycle the count sits at zero
    assign expire = s_q.busy && (s_q.cnt == '0) && !done && !load;
    assign count = s_q.cnt;
    assign busy = s_q.busy;

    // Load, count down, stop on completion or at zero
    always_comb begin
        s_d = s_q;
        if (load) begin
            s_d.busy = 1'b1;
            s_d.cnt = preload;
        end else if (s_q.busy) begin
            if (done || s_q.cnt == '0) begin
                s_d.busy = 1'b0; // Off mode simply parks here
            end else begin
                s_d.cnt = s_q.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

endmodule
`default_nettype wire

// ### rtl/pfs_ctrl.sv
// Fail-safe supervision, delayed read discard and interrupt gating.
// Assumes the target core presents decoded register strobes and
// local bus handshake pulses, all synchronous to the PCI clock.
//
// How it works
// - Global status shows write FIFO not empty while entries remain.
// - Discard flag sets when a region-two delayed read times out.
// - Timer expiry outside off mode sets the access timeout error flag.
// - Control register resets to zero except bit 17, selecting halt.
// - Hold bit clear drops fetched data on another transaction; set keeps it.
// - Core interrupts reach the PCI pin only while bit 21 is set.
// - Bit 20 lets a region-two delayed read discard raise the PCI interrupt.
// - Bit 19 lets an access timeout raise the interrupt, off mode excepted.
// - With autoclear, upper-half global read clears fail-safe interrupt and error.
// - Timeout error when the core handshake exceeds the programmed limit.
// - Mode field bits 17:16 encode off, retry, halt and skip.
// - Off mode waits forever and never flags or interrupts.
// - Retry mode reissues the same transfer at each expiry.
// - Halt mode target-aborts all later transfers until interrupt clears.
// - Skip mode drops the current transfer and moves on.
// - Timer register is read-only, live count low, zeros high.
// - PCI interrupt drives on any enabled active source; flag reports it.
// - Fail-safe timer loads at access start, counts down, expires at zero.
// - Discard timer loads at read completion, counts up, stops at bit 15.
`default_nettype none
`include "pfs_params.svh"
module pfs_ctrl #(
    parameter logic [15:0] PRELOAD_RST = `PFS_PRELOAD_RST,
    parameter logic [15:0] DTMR_PRELOAD = `PFS_DTMR_RST
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Register access from the target core
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [11:0] reg_addr,
    input wire logic [3:0] reg_be,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // Local bus handshake toward the terminal core
    input wire logic lb_start,
    input wire logic lb_done,
    output logic lb_reissue,
    output logic lb_skip,
    output logic pci_abort,
    // Posted write FIFO state
    input wire logic wfifo_not_empty,
    // Delayed read tracking
    input wire logic dr_fetched,
    input wire logic dr_bar1,
    input wire logic dr_repeat,
    input wire logic dr_other,
    output logic dr_data_valid,
    output logic dr_discard,
    // Terminal core interrupt and reset
    input wire logic core_irq,
    output logic core_rst,
    // PCI interrupt pin, open drain
    output logic pci_int_o,
    output logic pci_int_oe
);

    pfs_pkg::pfs_state_s s_q;
    pfs_pkg::pfs_state_s s_d;

    logic [15:0] tmr_count;
    logic tmr_busy;
    logic tmr_expire;
    logic tmr_load;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] pfs_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] be
    );
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Access held off while halted, reload on a retry reissue
    assign tmr_load = (lb_start && !s_q.abort) || s_q.reissue;

    pfs_fs_timer #(
        .W(16)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .load(tmr_load),
        .done(lb_done),
        .preload(s_q.preload),
        .count(tmr_count),
        .busy(tmr_busy),
        .expire(tmr_expire)
    );

    // Outputs straight from the state flops; open-drain pin level tied low
    assign reg_rdata = s_q.rdata;
    assign lb_reissue = s_q.reissue;
    assign lb_skip = s_q.skip;
    assign pci_abort = s_q.abort;
    assign dr_data_valid = s_q.dr_valid;
    assign dr_discard = s_q.dr_discard;
    assign core_rst = s_q.core_rst;
    assign pci_int_o = 1'b0;
    assign pci_int_oe = s_q.irq;

    // Next-state logic for the block outside the fail-safe timer
    always_comb begin
        pfs_pkg::pfs_mode_e mode;
        logic fs_hit;
        logic upper_rd;
        logic wr_ctrl;
        logic wr_pre;
        logic wr_cmd;
        logic [31:0] g;
        logic [31:0] pre_w;

        s_d = s_q;
        g = 32'h0000_0000;
        pre_w = 32'h0000_0000;
        mode = pfs_pkg::pfs_mode_e'(s_q.ctrl[`PFS_B_MODE_HI:`PFS_B_MODE_LO]);
        fs_hit = tmr_expire && (mode != pfs_pkg::PFS_OFF);
        upper_rd = reg_rd && (reg_addr == `PFS_OFS_GLOBAL) && (|reg_be[3:2]);
        wr_ctrl = reg_wr && (reg_addr == `PFS_OFS_CTRL);
        wr_pre = reg_wr && (reg_addr == `PFS_OFS_PRELOAD);
        wr_cmd = reg_wr && (reg_addr == `PFS_OFS_CMD);

        // Pulses last one cycle
        s_d.reissue = 1'b0;
        s_d.skip = 1'b0;
        s_d.core_rst = 1'b0;
        s_d.dr_discard = 1'b0;

        // Clears first so that a same-cycle event still lands
        if (upper_rd && s_q.ctrl[`PFS_B_AUTOCLR]) begin
            s_d.fs_irq = 1'b0;
            s_d.fs_err = 1'b0;
        end
        if (wr_cmd && reg_be[0] && reg_wdata[`PFS_C_CLRFS]) begin
            s_d.fs_irq = 1'b0;
            s_d.fs_err = 1'b0;
        end
        if (upper_rd) begin
            s_d.disc_flag = 1'b0;
        end

        // Timer expiry handling per recovery mode
        if (fs_hit) begin
            s_d.fs_err = 1'b1;
            s_d.fs_irq = 1'b1;
            unique case (mode)
                pfs_pkg::PFS_RETRY: s_d.reissue = 1'b1;
                pfs_pkg::PFS_HALT: s_d.abort = 1'b1;
                pfs_pkg::PFS_SKIP: s_d.skip = 1'b1;
                pfs_pkg::PFS_OFF: s_d.abort = s_q.abort;
            endcase
        end
        // Abort lifts only once the fail-safe interrupt is gone
        if (!s_d.fs_irq) begin
            s_d.abort = 1'b0;
        end

        // Delayed read hold and discard timer
        if (dr_fetched) begin
            s_d.dr_valid = 1'b1;
            s_d.dr_run = 1'b1;
            s_d.dr_bar1 = dr_bar1;
            s_d.dr_cnt = DTMR_PRELOAD;
        end else if (s_q.dr_valid) begin
            if (dr_repeat) begin
                s_d.dr_valid = 1'b0;
                s_d.dr_run = 1'b0;
            end else if (dr_other && !s_q.ctrl[`PFS_B_HOLD]) begin
                s_d.dr_valid = 1'b0;
                s_d.dr_run = 1'b0;
            end else if (s_q.dr_run) begin
                if (s_q.dr_cnt[`PFS_DTMR_TERM]) begin
                    // Terminal count: stop and throw the data away
                    s_d.dr_valid = 1'b0;
                    s_d.dr_run = 1'b0;
                    s_d.dr_discard = 1'b1;
                    if (s_q.dr_bar1) begin
                        s_d.disc_flag = 1'b1;
                    end
                end else begin
                    s_d.dr_cnt = s_q.dr_cnt + 16'h0001;
                end
            end
        end

        // Interrupt gating onto the PCI pin
        s_d.irq = (core_irq && s_q.ctrl[`PFS_B_EN_CORE])
            || (s_q.disc_flag && s_q.ctrl[`PFS_B_EN_DISC])
            || (s_q.fs_irq && s_q.ctrl[`PFS_B_EN_FS]
                && (mode != pfs_pkg::PFS_OFF));

        // Register writes; reserved control bits are kept at zero
        if (wr_ctrl) begin
            s_d.ctrl = pfs_merge(s_q.ctrl, reg_wdata, reg_be) & `PFS_CTRL_WMASK;
        end
        if (wr_pre) begin
            // Merge as a full word, keep only the timer half
            pre_w = pfs_merge({16'h0000, s_q.preload}, reg_wdata, reg_be);
            s_d.preload = pre_w[15:0];
        end
        if (wr_cmd && reg_be[0] && reg_wdata[`PFS_C_CORERST]) begin
            s_d.core_rst = 1'b1;
        end

        // Global activity word
        g[`PFS_G_IRQ] = s_q.irq;
        g[`PFS_G_FIFO] = wfifo_not_empty;
        g[`PFS_G_ONE] = 1'b1;
        g[`PFS_G_DISC] = s_q.disc_flag;
        g[`PFS_G_FSERR] = s_q.fs_err;
        g[`PFS_G_CORE] = core_irq;

        // Read data, unmapped offsets return zero
        if (reg_rd) begin
            unique case (reg_addr)
                `PFS_OFS_GLOBAL: s_d.rdata = g;
                `PFS_OFS_CTRL: s_d.rdata = s_q.ctrl;
                `PFS_OFS_TMR: s_d.rdata = {16'h0000, tmr_count};
                `PFS_OFS_PRELOAD: s_d.rdata = {16'h0000, s_q.preload};
                `PFS_OFS_DTMR: s_d.rdata = {16'h0000, s_q.dr_cnt};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register; the enable freezes everything
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.ctrl <= `PFS_CTRL_RST;
            s_q.preload <= PRELOAD_RST; // Parameter lets short limits be built
        end else if (ce) begin
            s_q <= s_d;
        end
    end

endmodule
`default_nettype wire

// ### sim/pfs_ctrl_assertions.sv
// Port-level checks for the fail-safe supervision block.
// Assumes one clock domain with the clock enable held high.
`default_nettype none
module pfs_ctrl_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register side
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_rdata,
    input wire logic wfifo_not_empty,
    // Local bus and delayed read side
    input wire logic lb_reissue,
    input wire logic lb_skip,
    input wire logic pci_abort,
    input wire logic dr_fetched,
    input wire logic dr_repeat,
    input wire logic dr_data_valid,
    input wire logic dr_discard
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_retry_pulse; lb_reissue |=> !lb_reissue; endproperty
    a_retry_pulse: assert property (p_retry_pulse) else $error("reissue wider than one cycle");
    property p_skip_pulse; lb_skip |=> !lb_skip; endproperty
    a_skip_pulse: assert property (p_skip_pulse) else $error("skip wider than one cycle");
    property p_one_mode; !(lb_reissue && lb_skip); endproperty
    a_one_mode: assert property (p_one_mode) else $error("retry and skip together");
    // Abort may only drop after some register access clears it
    property p_abort_hold; pci_abort && !reg_rd && !reg_wr |=> pci_abort; endproperty
    a_abort_hold: assert property (p_abort_hold) else $error("abort dropped uncleared");
    property p_repeat_drop; dr_repeat && !dr_fetched |=> !dr_data_valid; endproperty
    a_repeat_drop: assert property (p_repeat_drop) else $error("data kept after repeat");
    property p_disc_drop; dr_discard && !$past(dr_fetched) |-> !dr_data_valid; endproperty
    a_disc_drop: assert property (p_disc_drop) else $error("data kept after discard");
    property p_tmr_hi; reg_rd && reg_addr == 12'h808 |=> reg_rdata[31:16] == 16'h0000; endproperty
    a_tmr_hi: assert property (p_tmr_hi) else $error("timer upper half not zero");
    property p_glob;
        reg_rd && reg_addr == 12'h800 |=> reg_rdata[24] && reg_rdata[30] == $past(wfifo_not_empty);
    endproperty
    a_glob: assert property (p_glob) else $error("global status fifo or constant bit wrong");
endmodule

bind pfs_ctrl pfs_ctrl_assertions chk_u (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .wfifo_not_empty(wfifo_not_empty), .lb_reissue(lb_reissue), .lb_skip(lb_skip),
    .pci_abort(pci_abort), .dr_fetched(dr_fetched), .dr_repeat(dr_repeat),
    .dr_data_valid(dr_data_valid), .dr_discard(dr_discard));
`default_nettype wire

// ### sim/pfs_master_model.sv
// Bus master model issuing single register reads and writes.
// Assumes strobes are taken at the edge after they are raised.
`default_nettype none
module pfs_master_model (
    // Clock
    input wire logic clk,
    // Register access
    output var logic reg_rd,
    output var logic reg_wr,
    output var logic [11:0] reg_addr,
    output var logic [3:0] reg_be,
    output var logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {reg_rd, reg_wr, reg_addr, reg_be, reg_wdata} = '0;

    // Callers keep reserved bits zero; released address and data lines toggle, byte enables hold
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_be <= 4'hf;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~v;
    endtask

    // Read data is taken once the registered answer has landed
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        reg_be <= 4'hf;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        v = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the fail-safe supervision block.
// Assumes the master model carries all register traffic.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] pv = '0;
    logic bar1 = 1'b0;
    logic core_irq = 1'b0;
    logic fifo = 1'b0;
    logic rd, wr, reissue, skip, abort, valid, disc, core_rst, int_o, int_oe;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata, rdata, d;
    int n_fail = 0;
    int total_checks = 0;
    int n_re = 0;
    int n_sk = 0;
    int n_dd = 0;
    int n_cr = 0;
    int r0, s0;

    // 10 MHz clock
    always #50 clk = ~clk;

    pfs_master_model m_u (.clk(clk), .reg_rd(rd), .reg_wr(wr), .reg_addr(addr), .reg_be(be),
        .reg_wdata(wdata), .reg_rdata(rdata));
    // Short limits keep each timeout within a few cycles
    pfs_ctrl #(.PRELOAD_RST(16'h0004), .DTMR_PRELOAD(16'h7ff8)) dut_u (.clk(clk),
        .rst_n(rst_n), .ce(1'b1), .reg_rd(rd), .reg_wr(wr), .reg_addr(addr), .reg_be(be),
        .reg_wdata(wdata), .reg_rdata(rdata), .lb_start(pv[0]), .lb_done(pv[1]),
        .lb_reissue(reissue), .lb_skip(skip), .pci_abort(abort), .wfifo_not_empty(fifo),
        .dr_fetched(pv[2]), .dr_bar1(bar1), .dr_repeat(pv[4]), .dr_other(pv[3]),
        .dr_data_valid(valid), .dr_discard(disc), .core_irq(core_irq), .core_rst(core_rst),
        .pci_int_o(int_o), .pci_int_oe(int_oe));

    // Pulse tallies, compared as deltas
    always @(posedge clk) begin
        n_re <= n_re + int'(reissue === 1'b1);
        n_sk <= n_sk + int'(skip === 1'b1);
        n_dd <= n_dd + int'(disc === 1'b1);
        n_cr <= n_cr + int'(core_rst === 1'b1);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic pulse(input int b);
        @(posedge clk);
        pv[b] <= 1'b1;
        @(posedge clk);
        pv[b] <= 1'b0;
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Whole run needs under two hundred cycles
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        m_u.rd(12'h804, d);
        chk(d, 32'h0002_0000);
        fifo <= 1'b1;
        m_u.rd(12'h800, d);
        chk(d, 32'h4100_0000);
        fifo <= 1'b0;
        $display("reset test done");
        // Each recovery mode against a stalled core access
        for (int m = 0; m < 4; m++) begin
            r0 = n_re;
            s0 = n_sk;
            m_u.wr(12'h804, {12'h0, 1'b1, m == 3, 2'(m), 16'h0});
            pulse(0);
            m_u.rd(12'h808, d);
            chk(32'(d inside {32'h2, 32'h3, 32'h4}), 32'h1);
            repeat (12) @(posedge clk);
            chk(32'(n_re > r0), 32'(m == 1));
            chk(32'(n_sk > s0), 32'(m == 3));
            chk(32'(abort), 32'(m == 2));
            chk(32'(int_oe), 32'(m != 0));
            pulse(1);
            chk(32'(abort), 32'(m == 2));
            m_u.rd(12'h800, d);
            chk(d, {m != 0, 7'h01, 1'b0, m != 0, 22'h0});
            if (m != 3) begin
                m_u.wr(12'h81c, 32'h0000_0002);
            end
            m_u.rd(12'h800, d);
            chk(d, 32'h0100_0000);
            chk(32'(abort | int_oe), 32'h0);
            $display("mode %0d test done", m);
        end
        // Core interrupt reaches the pin only when enabled
        core_irq <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'(int_oe), 32'h0);
        m_u.wr(12'h804, 32'h0020_0000);
        m_u.rd(12'h800, d);
        chk(d, 32'h8101_0000);
        core_irq <= 1'b0;
        $display("core interrupt test done");
        // Fetched data meets a different transaction, hold off then on
        for (int h = 0; h < 2; h++) begin
            m_u.wr(12'h804, {h == 1, 31'h0});
            pulse(2);
            pulse(3);
            @(posedge clk);
            chk(32'(valid), 32'(h));
            pulse(4);
            @(posedge clk);
            chk(32'(valid), 32'h0);
        end
        $display("hold test done");
        // Region-two read left unclaimed until the discard timer runs out
        m_u.wr(12'h804, 32'h0010_0000);
        bar1 <= 1'b1;
        r0 = n_dd;
        pulse(2);
        repeat (14) @(posedge clk);
        chk(32'(n_dd - r0), 32'h1);
        chk(32'(int_oe), 32'h1);
        m_u.rd(12'h800, d);
        chk(d, 32'h8180_0000);
        m_u.rd(12'h800, d);
        chk(d, 32'h0100_0000);
        $display("discard test done");
        // Preload and discard count readback, core reset command, idle pin level
        m_u.rd(12'h80c, d);
        chk(d, 32'h0000_0004);
        m_u.rd(12'h810, d);
        chk(d, 32'h0000_8000);
        r0 = n_cr;
        m_u.wr(12'h81c, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk(32'(n_cr - r0), 32'h1);
        chk(32'(int_o), 32'h0);
        $display("register test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
